//--- hw/hcc_pkg.sv
package hcc_pkg;

	// Host I/O port addresses of the graphics controller index and data ports.
	localparam logic [15:0] HCC_PORT_INDEX = 16'h03ce;
	localparam logic [15:0] HCC_PORT_DATA = 16'h03cf;

	// Register indexes of the cursor bank; they run consecutively.
	localparam logic [7:0] HCC_IDX_X_POS_LOW = 8'h23;
	localparam logic [7:0] HCC_IDX_X_POS_HIGH = 8'h24;
	localparam logic [7:0] HCC_IDX_Y_POS_LOW = 8'h25;
	localparam logic [7:0] HCC_IDX_Y_POS_HIGH = 8'h26;
	localparam logic [7:0] HCC_IDX_COLOR0_LOW = 8'h27;
	localparam logic [7:0] HCC_IDX_COLOR0_MID = 8'h28;
	localparam logic [7:0] HCC_IDX_COLOR0_HIGH = 8'h29;
	localparam logic [7:0] HCC_IDX_COLOR1_LOW = 8'h2a;
	localparam logic [7:0] HCC_IDX_COLOR1_MID = 8'h2b;
	localparam logic [7:0] HCC_IDX_COLOR1_HIGH = 8'h2c;
	localparam logic [7:0] HCC_IDX_PATTERN_CONTROL = 8'h2d;
	localparam logic [7:0] HCC_IDX_Y_ORIGIN = 8'h2e;
	localparam logic [7:0] HCC_IDX_X_ORIGIN = 8'h2f;

	// Number of registers in the bank.
	localparam int HCC_NUM_REGS = 13;

	// Writable bit masks; reserved bits are held at zero.
	localparam logic [7:0] HCC_MASK_FULL = 8'hff;
	localparam logic [7:0] HCC_MASK_X_POS_HIGH = 8'h87;
	localparam logic [7:0] HCC_MASK_Y_POS_HIGH = 8'h07;
	localparam logic [7:0] HCC_MASK_PATTERN_CONTROL = 8'h0f;
	localparam logic [7:0] HCC_MASK_Y_ORIGIN = 8'h3f;
	localparam logic [7:0] HCC_MASK_X_ORIGIN = 8'hbf;

	// Value of every register after reset.
	localparam logic [7:0] HCC_RESET_VALUE = 8'h00;

	// Field positions.
	localparam int HCC_BIT_ENABLE = 0;
	localparam int HCC_BIT_SMALL = 1;
	localparam int HCC_BIT_PAT_LO = 2;
	localparam int HCC_BIT_PAT_HI = 3;
	localparam int HCC_BIT_EXT_CHAR = 7;
	localparam int HCC_BIT_ORIGIN_TOP = 5;

	// Pattern offsets within the top display memory bank.
	localparam logic [15:0] HCC_PAT_SMALL_BASE = 16'hfc00;
	localparam logic [15:0] HCC_PAT_LARGE_BASE = 16'hf800;
	localparam logic [15:0] HCC_PAT_LARGE_ALT = 16'hfc00;

endpackage : hcc_pkg

//--- hw/hcc_cursor_regs.sv
// Summary of operation
// - Index at port 3CE, data through 3CF.
// - X position: low byte plus three high bits.
// - Writing X low commits horizontal position.
// - Y position: low byte plus three high bits.
// - Writing Y low commits vertical position.
// - X low bits 2-0 give character position.
// - X high bit 7 extends character position.
// - Colour 0 is three bytes, indexes 27h-29h.
// - Colour 1 is three bytes, indexes 2Ah-2Ch.
// - Colour takes effect on high byte write.
// - Pattern control bit 0 enables cursor.
// - Bit 1: one is 32x32, zero 64x64.
// - Small cursor: bits 3-2 pick FC00h-FF00h.
// - Large cursor: bit 2 picks F800h or FC00h.
// - Pattern always sits in top memory bank.
// - Y origin bits 5-0; bit 5 small-ignored.
// - X origin bits 5-0; bit 5 small-unused.
`timescale 1ns/10ps
`default_nettype none

module hcc_cursor_regs
	import hcc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [15:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	output logic io_rd_hit,
	input wire logic [3:0] mem_top_bank,
	output logic cur_enable,
	output logic cur_small,
	output logic [10:0] cur_x_pos,
	output logic [10:0] cur_y_pos,
	output logic [3:0] cur_char_pos,
	output logic [23:0] cur_color0,
	output logic [23:0] cur_color1,
	output logic [19:0] cur_pat_addr,
	output logic [5:0] cur_x_origin,
	output logic [5:0] cur_y_origin
);

	// Returns the writable mask of a bank slot; reserved bits stay zero.
	function automatic logic [7:0] hcc_mask(input logic [7:0] idx);
		case (idx)
			HCC_IDX_X_POS_HIGH: hcc_mask = HCC_MASK_X_POS_HIGH;
			HCC_IDX_Y_POS_HIGH: hcc_mask = HCC_MASK_Y_POS_HIGH;
			HCC_IDX_PATTERN_CONTROL: hcc_mask = HCC_MASK_PATTERN_CONTROL;
			HCC_IDX_Y_ORIGIN: hcc_mask = HCC_MASK_Y_ORIGIN;
			HCC_IDX_X_ORIGIN: hcc_mask = HCC_MASK_X_ORIGIN;
			default: hcc_mask = HCC_MASK_FULL;
		endcase
	endfunction : hcc_mask

	// Tells whether an index falls inside the cursor bank.
	function automatic logic hcc_in_bank(input logic [7:0] idx);
		hcc_in_bank = (idx >= HCC_IDX_X_POS_LOW) && (idx <= HCC_IDX_X_ORIGIN);
	endfunction : hcc_in_bank

	logic [7:0] index_reg; // Index latched from the index port.
	logic [7:0] bank_reg [0:HCC_NUM_REGS-1]; // Software visible register bank.
	logic [10:0] x_pos_reg; // Committed horizontal position.
	logic [10:0] y_pos_reg; // Committed vertical position.
	logic [3:0] char_pos_reg; // Committed position within a character cell.
	logic [23:0] color0_reg; // Committed colour 0.
	logic [23:0] color1_reg; // Committed colour 1.
	logic [7:0] rdata_reg; // Read data held for the host.
	logic hit_reg; // The last read was answered by this bank.
	logic data_wr; // A write to the data port.
	logic [7:0] slot_idx; // Bank slot selected by the index.
	logic [7:0] rd_value; // Value returned for the current index.
	logic [15:0] pat_offset; // Pattern offset within the top bank.

	// A data port write reaches the slot picked by the index.
	assign data_wr = io_wr && (io_addr == HCC_PORT_DATA);
	assign slot_idx = index_reg - HCC_IDX_X_POS_LOW;

	// The index port takes the register number for later data accesses.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			index_reg <= HCC_RESET_VALUE;
		end else if (io_wr && (io_addr == HCC_PORT_INDEX)) begin
			index_reg <= io_wdata;
		end
	end

	// Each bank slot stores its writable bits; reserved bits never set.
	genvar gi;
	generate
		for (gi = 0; gi < HCC_NUM_REGS; gi++) begin : g_bank
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					bank_reg[gi] <= HCC_RESET_VALUE;
				end else if (data_wr && (index_reg == HCC_IDX_X_POS_LOW + 8'(gi))) begin
					bank_reg[gi] <= io_wdata & hcc_mask(index_reg);
				end
			end
		end
	endgenerate

	// Horizontal position and cell position move only on the X low write.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			x_pos_reg <= 11'h000;
			char_pos_reg <= 4'h0;
		end else if (data_wr && (index_reg == HCC_IDX_X_POS_LOW)) begin
			// The high part was staged earlier by software.
			x_pos_reg <= {bank_reg[1][2:0], io_wdata};
			char_pos_reg <= {bank_reg[1][HCC_BIT_EXT_CHAR], io_wdata[2:0]};
		end
	end

	// Vertical position moves only on the Y low write.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			y_pos_reg <= 11'h000;
		end else if (data_wr && (index_reg == HCC_IDX_Y_POS_LOW)) begin
			// The high part was staged earlier by software.
			y_pos_reg <= {bank_reg[3][2:0], io_wdata};
		end
	end

	// Colours take the staged bytes when their high byte is written.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			color0_reg <= 24'h000000;
			color1_reg <= 24'h000000;
		end else if (data_wr) begin
			// Lower bytes were loaded before the high byte.
			if (index_reg == HCC_IDX_COLOR0_HIGH) begin
				color0_reg <= {io_wdata, bank_reg[5], bank_reg[4]};
			end
			if (index_reg == HCC_IDX_COLOR1_HIGH) begin
				color1_reg <= {io_wdata, bank_reg[8], bank_reg[7]};
			end
		end
	end

	// Read value of the selected slot; other indexes read as zero.
	always_comb begin
		rd_value = 8'h00;
		if (io_addr == HCC_PORT_INDEX) begin
			rd_value = index_reg;
		end else if ((io_addr == HCC_PORT_DATA) && hcc_in_bank(index_reg)) begin
			rd_value = bank_reg[slot_idx[3:0]];
		end
	end

	// Read data is registered and answered on the next clock.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rdata_reg <= 8'h00;
			hit_reg <= 1'b0;
		end else if (io_rd) begin
			rdata_reg <= rd_value;
			hit_reg <= (io_addr == HCC_PORT_INDEX) ||
				((io_addr == HCC_PORT_DATA) && hcc_in_bank(index_reg));
		end else begin
			hit_reg <= 1'b0;
		end
	end

	// Pattern offset follows the size and pattern selection bits.
	always_comb begin
		if (bank_reg[10][HCC_BIT_SMALL]) begin
			pat_offset = HCC_PAT_SMALL_BASE |
				{6'h00, bank_reg[10][HCC_BIT_PAT_HI:HCC_BIT_PAT_LO], 8'h00};
		end else if (bank_reg[10][HCC_BIT_PAT_LO]) begin
			pat_offset = HCC_PAT_LARGE_ALT;
		end else begin
			pat_offset = HCC_PAT_LARGE_BASE;
		end
	end

	// Outputs toward the cursor display logic.
	assign io_rdata = rdata_reg;
	assign io_rd_hit = hit_reg;
	assign cur_enable = bank_reg[10][HCC_BIT_ENABLE];
	assign cur_small = bank_reg[10][HCC_BIT_SMALL];
	assign cur_x_pos = x_pos_reg;
	assign cur_y_pos = y_pos_reg;
	assign cur_char_pos = char_pos_reg;
	assign cur_color0 = color0_reg;
	assign cur_color1 = color1_reg;
	assign cur_pat_addr = {mem_top_bank, pat_offset};
	// Bit 5 of each origin is dropped for the small cursor.
	assign cur_y_origin = {bank_reg[11][HCC_BIT_ORIGIN_TOP] & ~cur_small,
		bank_reg[11][4:0]};
	assign cur_x_origin = {bank_reg[12][HCC_BIT_ORIGIN_TOP] & ~cur_small,
		bank_reg[12][4:0]};

	// Checks of the committed values against their causes.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	logic wr_xlo, wr_xhi, wr_ylo, wr_yhi, wr_c0h, wr_c1h, wr_pat;
	assign wr_xlo = data_wr && (index_reg == HCC_IDX_X_POS_LOW);
	assign wr_xhi = data_wr && (index_reg == HCC_IDX_X_POS_HIGH);
	assign wr_ylo = data_wr && (index_reg == HCC_IDX_Y_POS_LOW);
	assign wr_yhi = data_wr && (index_reg == HCC_IDX_Y_POS_HIGH);
	assign wr_c0h = data_wr && (index_reg == HCC_IDX_COLOR0_HIGH);
	assign wr_c1h = data_wr && (index_reg == HCC_IDX_COLOR1_HIGH);
	assign wr_pat = data_wr && (index_reg == HCC_IDX_PATTERN_CONTROL);

	// Shadow copies of what the host wrote, kept apart from the bank so that the
	// checks below do not simply repeat the datapath that they guard.
	logic [7:0] xhi_seen_reg; // Last byte written to the X high slot.
	logic [7:0] yhi_seen_reg; // Last byte written to the Y high slot.
	logic [15:0] c0_seen_reg; // Last mid and low bytes written for colour 0.

	// Remembers the X high byte as it crossed the data port.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			xhi_seen_reg <= HCC_RESET_VALUE;
		end else if (wr_xhi) begin
			xhi_seen_reg <= io_wdata;
		end
	end

	// Remembers the Y high byte as it crossed the data port.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			yhi_seen_reg <= HCC_RESET_VALUE;
		end else if (wr_yhi) begin
			yhi_seen_reg <= io_wdata;
		end
	end

	// Remembers the colour 0 low and mid bytes as they crossed the data port.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			c0_seen_reg <= 16'h0000;
		end else if (data_wr && (index_reg == HCC_IDX_COLOR0_LOW)) begin
			c0_seen_reg[7:0] <= io_wdata;
		end else if (data_wr && (index_reg == HCC_IDX_COLOR0_MID)) begin
			c0_seen_reg[15:8] <= io_wdata;
		end
	end

	AST_INDEX_LOAD: assert property (
		io_wr && io_addr == HCC_PORT_INDEX |=> index_reg == $past(io_wdata))
		else $error("Index port write did not select the register.");
	AST_INDEX_THEN_DATA: assert property (
		io_rd && io_addr == HCC_PORT_DATA && index_reg == HCC_IDX_COLOR0_LOW
		|=> io_rdata == $past(c0_seen_reg[7:0]))
		else $error("Data port did not return the written colour byte.");
	AST_XPOS_COMMIT: assert property (
		wr_xlo |=> cur_x_pos == {$past(xhi_seen_reg[2:0]), $past(io_wdata)})
		else $error("X position not committed from staged high and written low.");
	AST_X_ONLY_ON_LOW: assert property (
		!wr_xlo |=> $stable(cur_x_pos) && $stable(cur_char_pos))
		else $error("X position moved without an X low write.");
	AST_XHI_NO_MOVE: assert property (wr_xhi && !wr_xlo |=> $stable(cur_x_pos))
		else $error("X position moved on a high byte write.");
	AST_YPOS_COMMIT: assert property (
		wr_ylo |=> cur_y_pos == {$past(yhi_seen_reg[2:0]), $past(io_wdata)})
		else $error("Y position not committed from staged high and written low.");
	AST_Y_ONLY_ON_LOW: assert property (!wr_ylo |=> $stable(cur_y_pos))
		else $error("Y position moved without a Y low write.");
	AST_YHI_NO_MOVE: assert property (wr_yhi |=> $stable(cur_y_pos))
		else $error("Y position moved on a high byte write.");
	AST_CHAR_POS: assert property (
		wr_xlo |=> cur_char_pos == {$past(xhi_seen_reg[7]), $past(io_wdata[2:0])})
		else $error("Character cell position wrong after X commit.");
	AST_COLOR0_COMMIT: assert property (
		wr_c0h |=> cur_color0 == {$past(io_wdata), $past(c0_seen_reg)})
		else $error("Colour 0 not committed from the staged bytes and the high byte.");
	AST_COLOR_ONLY_ON_HIGH: assert property (
		!wr_c0h && !wr_c1h |=> $stable(cur_color0) && $stable(cur_color1))
		else $error("A colour changed without a high byte write.");
	AST_COLOR1_HOLD: assert property (
		data_wr && index_reg == HCC_IDX_COLOR1_LOW |=> $stable(cur_color1))
		else $error("Colour 1 changed before its high byte was written.");
	AST_ENABLE_SIZE: assert property (
		wr_pat |=> cur_enable == $past(io_wdata[0]) && cur_small == $past(io_wdata[1]))
		else $error("Enable or size does not follow the pattern control write.");
	AST_PAT_LARGE: assert property (
		!cur_small |-> cur_pat_addr[15:0] == HCC_PAT_LARGE_BASE ||
		cur_pat_addr[15:0] == HCC_PAT_LARGE_ALT)
		else $error("Large cursor pattern outside its two locations.");
	AST_PAT_BANK: assert property (cur_pat_addr[19:16] == mem_top_bank)
		else $error("Pattern not in the top memory bank.");
	AST_SMALL_PAT: assert property (
		cur_small |-> cur_pat_addr[15:10] == 6'h3f && cur_pat_addr[7:0] == 8'h00 &&
		cur_pat_addr[9:8] == bank_reg[10][HCC_BIT_PAT_HI:HCC_BIT_PAT_LO])
		else $error("Small cursor pattern outside its four locations.");
	AST_ORIGIN_SMALL: assert property (cur_small |-> !cur_y_origin[5] && !cur_x_origin[5])
		else $error("Origin bit 5 used for the small cursor.");
	AST_RESERVED_ZERO: assert property (
		io_rd && io_addr == HCC_PORT_DATA && index_reg == HCC_IDX_Y_POS_HIGH
		|=> io_rdata[7:3] == 5'h00)
		else $error("Reserved bits of Y high read nonzero.");

	COV_X_COMMIT: cover property (wr_xhi ##[2:6] wr_xlo);
	COV_COLOR_COMMIT: cover property (wr_c0h ##[1:20] wr_c1h);
	COV_SMALL_ON: cover property (cur_enable && cur_small && cur_pat_addr[9:8] == 2'b11);
	COV_READBACK: cover property (io_rd && io_addr == HCC_PORT_DATA ##1 io_rd_hit);

endmodule : hcc_cursor_regs

`default_nettype wire

//--- dv/hcc_tb.sv
`timescale 1ns/10ps
`default_nettype none

module testbench
	import hcc_pkg::*;
;
	// Host port stimulus and observed outputs of the cursor bank.
	logic sys_clk, rst, io_wr, io_rd, io_rd_hit, cur_enable, cur_small;
	logic [15:0] io_addr;
	logic [7:0] io_wdata, io_rdata, lo, mid, hi;
	logic [3:0] mem_top_bank, cur_char_pos;
	logic [10:0] cur_x_pos, cur_y_pos;
	logic [23:0] cur_color0, cur_color1, col;
	logic [19:0] cur_pat_addr;
	logic [15:0] off;
	logic [5:0] cur_x_origin, cur_y_origin;
	logic [31:0] seed = 32'hdfcb;
	logic [7:0] exp_q[$];
	int err_total = 0, tests_run = 0, cycles = 0;

	hcc_cursor_regs uut (.sys_clk(sys_clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rd_hit(io_rd_hit),
		.mem_top_bank(mem_top_bank), .cur_enable(cur_enable), .cur_small(cur_small),
		.cur_x_pos(cur_x_pos), .cur_y_pos(cur_y_pos), .cur_char_pos(cur_char_pos),
		.cur_color0(cur_color0), .cur_color1(cur_color1), .cur_pat_addr(cur_pat_addr),
		.cur_x_origin(cur_x_origin), .cur_y_origin(cur_y_origin));

	// Free-running 50 MHz clock.
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// Next value of the xorshift sequence.
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs

	// Writable bits of each register; reserved bits must stay zero.
	function automatic logic [7:0] msk(input logic [7:0] idx);
		case (idx)
			HCC_IDX_X_POS_HIGH: return HCC_MASK_X_POS_HIGH;
			HCC_IDX_Y_POS_HIGH: return HCC_MASK_Y_POS_HIGH;
			HCC_IDX_PATTERN_CONTROL: return HCC_MASK_PATTERN_CONTROL;
			HCC_IDX_Y_ORIGIN: return HCC_MASK_Y_ORIGIN;
			HCC_IDX_X_ORIGIN: return HCC_MASK_X_ORIGIN;
			default: return HCC_MASK_FULL;
		endcase
	endfunction : msk

	// Counts a comparison and reports a mismatch at once.
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One write strobe, launched just after an edge and taken at the next.
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk) #1;
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		@(posedge sys_clk) #1;
		io_wr = 1'b0;
	endtask : wr

	// One read strobe; on a hit the expected byte is queued for the monitor.
	task automatic rd(input logic [15:0] a, input logic hit, input logic [7:0] e);
		@(posedge sys_clk) #1;
		io_addr = a;
		io_rd = 1'b1;
		if (hit) exp_q.push_back(e);
		@(posedge sys_clk) #1;
		io_rd = 1'b0;
		chk(24'(io_rd_hit), 24'(hit));
	endtask : rd

	// Indexed register write and read through the index and data ports.
	task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
		wr(HCC_PORT_INDEX, idx);
		wr(HCC_PORT_DATA, d);
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] idx, input logic [7:0] e);
		wr(HCC_PORT_INDEX, idx);
		rd(HCC_PORT_DATA, 1'b1, e);
	endtask : rd_reg

	// Prints the verdict and ends the run.
	task automatic print_verdict();
		if (err_total == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : print_verdict

	// Monitor: each answered read is compared with the oldest queued note.
	always @(posedge sys_clk) begin
		if (io_rd_hit === 1'b1) begin
			if (exp_q.size() == 0) begin
				err_total++;
				$display("wrong value at %0t: got %h expected none", $time, io_rdata);
			end else begin
				chk(24'(io_rdata), 24'(exp_q.pop_front()));
			end
		end
	end

	// Hang guard well above the length of the sequence.
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			print_verdict();
		end
	end

	// Main sequence.
	initial begin
		rst = 1'b1;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_addr = 16'h0000;
		io_wdata = 8'h00;
		mem_top_bank = 4'h5;
		repeat (5) @(posedge sys_clk);
		#1 rst = 1'b0;
		chk(24'(cur_pat_addr), {4'h0, 4'h5, HCC_PAT_LARGE_BASE});
		chk({cur_enable, cur_small, cur_x_pos, cur_y_pos}, 24'h000000);
		chk(24'({cur_x_origin, cur_y_origin, cur_char_pos}), 24'h000000);
		chk(cur_color0 | cur_color1, 24'h000000);
		for (int i = 0; i < HCC_NUM_REGS; i++) rd_reg(8'(8'h23 + i), HCC_RESET_VALUE);
		// Random bytes into every register, read back with reserved bits cleared.
		for (int i = 0; i < HCC_NUM_REGS; i++) begin
			seed = xs(seed);
			wr_reg(8'(8'h23 + i), seed[7:0]);
			rd_reg(8'(8'h23 + i), seed[7:0] & msk(8'(8'h23 + i)));
		end
		rd(HCC_PORT_INDEX, 1'b1, HCC_IDX_X_ORIGIN);
		wr(HCC_PORT_INDEX, 8'h30);
		rd(HCC_PORT_DATA, 1'b0, 8'h00);
		chk(24'(io_rdata), 24'h000000);
		rd(16'h03c0, 1'b0, 8'h00);
		// High half alone must not move the cursor; the low write commits.
		wr_reg(HCC_IDX_X_POS_HIGH, 8'h00);
		wr_reg(HCC_IDX_X_POS_LOW, 8'h00);
		wr_reg(HCC_IDX_X_POS_HIGH, 8'hfd);
		chk(24'(cur_x_pos), 24'h000000);
		wr_reg(HCC_IDX_X_POS_LOW, 8'h3e);
		chk({cur_char_pos, 9'h000, cur_x_pos}, {4'he, 9'h000, 11'h53e});
		wr_reg(HCC_IDX_Y_POS_HIGH, 8'h00);
		wr_reg(HCC_IDX_Y_POS_LOW, 8'h00);
		wr_reg(HCC_IDX_Y_POS_HIGH, 8'hfe);
		chk(24'(cur_y_pos), 24'h000000);
		wr_reg(HCC_IDX_Y_POS_LOW, 8'h77);
		chk(24'(cur_y_pos), 24'h000677);
		// Colours: staged bytes appear only on the high byte write.
		for (int c = 0; c < 2; c++) begin
			for (int r = 0; r < 2; r++) begin
				seed = xs(seed);
				{hi, mid, lo} = seed[23:0];
				wr_reg(8'(8'h27 + 3 * c), lo);
				wr_reg(8'(8'h28 + 3 * c), mid);
				if (r == 1) chk(c == 0 ? cur_color0 : cur_color1, col);
				wr_reg(8'(8'h29 + 3 * c), hi);
				col = {hi, mid, lo};
				chk(c == 0 ? cur_color0 : cur_color1, col);
			end
		end
		// Every pattern control code against a random top bank.
		for (int p = 0; p < 16; p++) begin
			seed = xs(seed);
			mem_top_bank = seed[3:0];
			wr_reg(HCC_IDX_PATTERN_CONTROL, 8'(p));
			if (p[1]) off = HCC_PAT_SMALL_BASE | {6'h00, 2'(p >> 2), 8'h00};
			else off = p[2] ? HCC_PAT_LARGE_ALT : HCC_PAT_LARGE_BASE;
			chk({22'h0, cur_small, cur_enable}, 24'(p & 3));
			chk(24'(cur_pat_addr), {4'h0, seed[3:0], off});
		end
		// Origins: bit 5 dropped for the small cursor only.
		wr_reg(HCC_IDX_Y_ORIGIN, 8'hff);
		wr_reg(HCC_IDX_X_ORIGIN, 8'hff);
		chk({12'h000, cur_x_origin, cur_y_origin}, 24'h0007df);
		wr_reg(HCC_IDX_PATTERN_CONTROL, 8'h00);
		chk({12'h000, cur_x_origin, cur_y_origin}, 24'h000fff);
		// A reset in mid-run clears the committed state as well as the bank.
		@(posedge sys_clk) #1 rst = 1'b1;
		@(posedge sys_clk) #1 rst = 1'b0;
		chk({cur_enable, cur_small, cur_x_pos, cur_y_pos}, 24'h000000);
		chk(24'({cur_x_origin, cur_y_origin, cur_char_pos}), 24'h000000);
		chk(cur_color0 | cur_color1, 24'h000000);
		chk(24'(cur_pat_addr), {4'h0, mem_top_bank, HCC_PAT_LARGE_BASE});
		rd_reg(HCC_IDX_X_ORIGIN, HCC_RESET_VALUE);
		repeat (3) @(posedge sys_clk);
		chk(24'(exp_q.size()), 24'h000000);
		print_verdict();
	end
endmodule : testbench

`default_nettype wire
